// File: wdt_pkg.sv
// package: register map, field positions and timing constants of the watchdog timer unit
package wdt_pkg;

	// ************************************
	// register byte addresses
	// ************************************
	localparam logic [7:0] WDT_ADDR_INT_EN  = 8'hA8;
	localparam logic [7:0] WDT_ADDR_KEY     = 8'hC7;
	localparam logic [7:0] WDT_ADDR_CTRL    = 8'hD8;
	localparam logic [7:0] WDT_ADDR_EXT_EN  = 8'hE8;
	localparam logic [7:0] WDT_ADDR_EXT_PRI = 8'hF8;
	localparam logic [7:0] WDT_ADDR_CLKCTL  = 8'h8C;

	// ************************************
	// field positions and reset values
	// ************************************
	localparam int unsigned WDT_BIT_GIE      = 7;
	localparam int unsigned WDT_BIT_DOG_EN   = 4;
	localparam int unsigned WDT_BIT_DOG_PRI  = 4;
	localparam int unsigned WDT_BIT_RESTART  = 0;
	localparam int unsigned WDT_BIT_RST_EN   = 1;
	localparam int unsigned WDT_BIT_RST_FLAG = 2;
	localparam int unsigned WDT_BIT_TO_FLAG  = 3;
	localparam int unsigned WDT_BIT_SEL_LO   = 6;
	localparam logic [7:0]  WDT_RST_INT_EN   = 8'h00;
	localparam logic [7:0]  WDT_RST_CTRL     = 8'h00;
	localparam logic [7:0]  WDT_RST_EXT_EN   = 8'h00;
	localparam logic [7:0]  WDT_RST_EXT_PRI  = 8'h00;
	localparam logic [7:0]  WDT_RST_CLKCTL   = 8'h03;

	// ************************************
	// unlock keys, vector, intervals
	// ************************************
	localparam logic [7:0]  WDT_KEY_FIRST    = 8'hAA;
	localparam logic [7:0]  WDT_KEY_SECOND   = 8'h55;
	localparam logic [7:0]  WDT_IRQ_VECTOR   = 8'h63;
	localparam logic [3:0]  WDT_IRQ_NATPRIO  = 4'hB;
	localparam int unsigned WDT_CNT_W        = 26;
	localparam int unsigned WDT_INT_0        = 131072;
	localparam int unsigned WDT_INT_1        = 1048576;
	localparam int unsigned WDT_INT_2        = 8388608;
	localparam int unsigned WDT_INT_3        = 67108864;
	localparam int unsigned WDT_RST_DELAY    = 512;
	localparam int unsigned WDT_DLY_W        = 10;

	typedef enum logic [1:0] {
		WDT_KEY_IDLE = 2'b00,
		WDT_KEY_GOT1 = 2'b01,
		WDT_KEY_OPEN = 2'b10
	} wdt_key_e;

	// software-visible control bits gathered for the core and the interrupt outputs
	typedef struct packed {
		logic       gie;
		logic       dog_en;
		logic       dog_pri;
		logic       rst_en;
		logic [1:0] sel;
	} wdt_cfg_s;

endpackage : wdt_pkg

// File: wdt_core.sv
// module: free-running watchdog counter with interval compare and reset countdown
`timescale 1ns/1ps
`default_nettype none
module wdt_core
	import wdt_pkg::*;
#(
	parameter int unsigned INT0 = WDT_INT_0,
	parameter int unsigned INT1 = WDT_INT_1,
	parameter int unsigned INT2 = WDT_INT_2,
	parameter int unsigned INT3 = WDT_INT_3
) (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic [1:0] dog_interval_sel,
	input  wire logic       dog_reset_enable,
	input  wire logic       restart,
	// events
	output logic            timeout_pulse,
	output logic            dog_reset_pulse,
	output logic [9:0]      delay_left
);
	logic [WDT_CNT_W:0]  count;
	logic [WDT_CNT_W:0]  limit;
	logic                armed;
	logic [WDT_DLY_W-1:0] dly;

	always_comb begin
		unique case (dog_interval_sel)
			2'b00: limit = (WDT_CNT_W+1)'(INT0);
			2'b01: limit = (WDT_CNT_W+1)'(INT1);
			2'b10: limit = (WDT_CNT_W+1)'(INT2);
			2'b11: limit = (WDT_CNT_W+1)'(INT3);
		endcase
	end

	assign timeout_pulse = (count + 1'b1 >= limit) && !restart;

	// the watchdog reset itself also restarts the count, it never disables the dog
	always_ff @(posedge aclk) begin
		if (!aresetn || restart || dog_reset_pulse || timeout_pulse) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || restart || dog_reset_pulse) begin
			armed <= 1'b0;
			dly   <= '0;
		end else if (timeout_pulse && dog_reset_enable && !armed) begin
			armed <= 1'b1;
			dly   <= WDT_DLY_W'(WDT_RST_DELAY);
		end else if (armed && !dog_reset_enable) begin
			armed <= 1'b0;
		end else if (armed) begin
			dly <= dly - 1'b1;
		end
	end

	// a restart landing in the very last cycle still cancels the reset
	assign dog_reset_pulse = armed && dog_reset_enable && (dly == '0) && !restart;
	assign delay_left      = armed ? dly : '0;

	chk_reset_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		(timeout_pulse && dog_reset_enable && !armed)
		|=> (armed && dly == WDT_DLY_W'(WDT_RST_DELAY)))
		else $error("countdown not loaded with full delay");
endmodule // wdt_core
`default_nettype wire

// File: wdt_top.sv
// module: watchdog timer unit with AXI4-Lite register slave and unlock sequence
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
	import wdt_pkg::*;
#(
	parameter int unsigned INT0 = WDT_INT_0,
	parameter int unsigned INT1 = WDT_INT_1,
	parameter int unsigned INT2 = WDT_INT_2,
	parameter int unsigned INT3 = WDT_INT_3
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// interrupt request to the interrupt controller
	output logic             dog_irq,
	output logic             dog_irq_high_prio,
	output logic [7:0]       dog_irq_vector,
	output logic [3:0]       dog_irq_natural_prio,
	// system reset request
	output logic             dog_sys_reset
);
	// ************************************
	// register state
	// ************************************
	logic [7:0] interrupt_enable_main;
	logic [7:0] extended_irq_enable;
	logic [7:0] extended_irq_priority;
	logic [1:0] dog_interval_sel;
	logic [5:0] clock_ctrl_low;
	logic       dog_reset_enable;
	logic       dog_restart;
	logic       dog_timeout_flag;
	logic       dog_reset_cause_flag;
	wdt_key_e   key_state;
	wdt_cfg_s   cfg;

	// ************************************
	// axi4-lite write channel
	// ************************************
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        wr_lane0;
	logic [7:0]  wbyte;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wr_lane0      = wr_fire && w_strb[0];
	assign wbyte         = w_data[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	logic wr_hit;
	always_comb begin
		unique case (aw_addr)
			WDT_ADDR_INT_EN, WDT_ADDR_KEY, WDT_ADDR_CTRL,
			WDT_ADDR_EXT_EN, WDT_ADDR_EXT_PRI, WDT_ADDR_CLKCTL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************
	// unlock sequence
	// ************************************
	logic wr_key;
	logic wr_ctrl;
	logic ctrl_ok;
	assign wr_key  = wr_lane0 && aw_addr == WDT_ADDR_KEY;
	assign wr_ctrl = wr_lane0 && aw_addr == WDT_ADDR_CTRL;
	assign ctrl_ok = wr_ctrl && key_state == WDT_KEY_OPEN;

	// any other write in between closes the lock again
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_state <= WDT_KEY_IDLE;
		end else if (wr_fire) begin
			unique case (key_state)
				WDT_KEY_IDLE: key_state <= (wr_key && wbyte == WDT_KEY_FIRST) ?
					WDT_KEY_GOT1 : WDT_KEY_IDLE;
				WDT_KEY_GOT1: key_state <= (wr_key && wbyte == WDT_KEY_SECOND) ?
					WDT_KEY_OPEN : WDT_KEY_IDLE;
				WDT_KEY_OPEN: key_state <= WDT_KEY_IDLE;
				default:      key_state <= WDT_KEY_IDLE;
			endcase
		end
	end

	// ************************************
	// plain registers
	// ************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable_main <= WDT_RST_INT_EN;
			extended_irq_enable   <= WDT_RST_EXT_EN;
			extended_irq_priority <= WDT_RST_EXT_PRI;
			{dog_interval_sel, clock_ctrl_low} <= WDT_RST_CLKCTL;
		end else if (wr_lane0) begin
			if (aw_addr == WDT_ADDR_INT_EN)
				interrupt_enable_main <= wbyte;
			if (aw_addr == WDT_ADDR_EXT_EN)
				extended_irq_enable <= wbyte;
			if (aw_addr == WDT_ADDR_EXT_PRI)
				extended_irq_priority <= wbyte;
			if (aw_addr == WDT_ADDR_CLKCTL)
				{dog_interval_sel, clock_ctrl_low} <= wbyte;
		end
	end

	assign cfg.gie     = interrupt_enable_main[WDT_BIT_GIE];
	assign cfg.dog_en  = extended_irq_enable[WDT_BIT_DOG_EN];
	assign cfg.dog_pri = extended_irq_priority[WDT_BIT_DOG_PRI];
	assign cfg.rst_en  = dog_reset_enable;
	assign cfg.sel     = dog_interval_sel;

	// ************************************
	// counter core
	// ************************************
	logic       timeout_pulse;
	logic       dog_reset_pulse;
	logic [9:0] delay_left;

	wdt_core #(
		.INT0 (INT0),
		.INT1 (INT1),
		.INT2 (INT2),
		.INT3 (INT3)
	) i_wdt_core (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.dog_interval_sel (cfg.sel),
		.dog_reset_enable (cfg.rst_en),
		.restart          (dog_restart),
		.timeout_pulse    (timeout_pulse),
		.dog_reset_pulse  (dog_reset_pulse),
		.delay_left       (delay_left)
	);

	// ************************************
	// control register: unlocked writes only
	// ************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dog_reset_enable <= WDT_RST_CTRL[WDT_BIT_RST_EN];
			dog_restart      <= WDT_RST_CTRL[WDT_BIT_RESTART];
		end else if (ctrl_ok) begin
			dog_reset_enable <= wbyte[WDT_BIT_RST_EN];
			dog_restart      <= wbyte[WDT_BIT_RESTART];
		end else begin
			dog_restart <= 1'b0;
		end
	end

	// hardware set wins over a same-cycle software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dog_timeout_flag <= WDT_RST_CTRL[WDT_BIT_TO_FLAG];
		end else if (timeout_pulse) begin
			dog_timeout_flag <= 1'b1;
		end else if (ctrl_ok) begin
			dog_timeout_flag <= wbyte[WDT_BIT_TO_FLAG];
		end
	end

	// a software-set cause flag does not itself trigger a reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dog_reset_cause_flag <= 1'b0;
		end else if (dog_reset_pulse) begin
			dog_reset_cause_flag <= 1'b1;
		end else if (ctrl_ok) begin
			dog_reset_cause_flag <= wbyte[WDT_BIT_RST_FLAG];
		end
	end

	// ************************************
	// outputs
	// ************************************
	assign dog_irq              = dog_timeout_flag && cfg.dog_en && cfg.gie;
	assign dog_irq_high_prio    = cfg.dog_pri;
	assign dog_irq_vector       = WDT_IRQ_VECTOR;
	assign dog_irq_natural_prio = WDT_IRQ_NATPRIO;
	assign dog_sys_reset        = dog_reset_pulse;

	// ************************************
	// axi4-lite read channel
	// ************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			unique case (s_axi_araddr[7:0])
				WDT_ADDR_INT_EN: s_axi_rdata <= {24'h000000, interrupt_enable_main};
				WDT_ADDR_KEY:    s_axi_rdata <= 32'h00000000;
				WDT_ADDR_CTRL:   s_axi_rdata <= {28'h0000000, dog_timeout_flag,
					dog_reset_cause_flag, dog_reset_enable, dog_restart};
				WDT_ADDR_EXT_EN: s_axi_rdata <= {24'h000000, extended_irq_enable};
				WDT_ADDR_EXT_PRI: s_axi_rdata <= {24'h000000, extended_irq_priority};
				WDT_ADDR_CLKCTL: s_axi_rdata <= {24'h000000, dog_interval_sel, clock_ctrl_low};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************
	// checks
	// ************************************
	chk_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
		dog_irq == (dog_timeout_flag && extended_irq_enable[4] && interrupt_enable_main[7]))
		else $error("irq gating wrong");
	chk_flag_on_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_pulse |=> dog_timeout_flag)
		else $error("timeout flag not set");
	chk_locked_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl && key_state != WDT_KEY_OPEN && !timeout_pulse && !dog_reset_pulse)
		|=> $stable(dog_reset_enable) && $stable(dog_timeout_flag))
		else $error("locked write changed control");
	chk_unlock_seq: assert property (@(posedge aclk) disable iff (!aresetn)
		(key_state == WDT_KEY_GOT1 && wr_key && wbyte == WDT_KEY_SECOND)
		|=> key_state == WDT_KEY_OPEN)
		else $error("unlock did not open");
	chk_restart_self: assert property (@(posedge aclk) disable iff (!aresetn)
		dog_restart && !ctrl_ok |=> !dog_restart)
		else $error("restart bit stuck");
	chk_reset_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		dog_sys_reset |=> dog_reset_cause_flag)
		else $error("reset cause not set");
	chk_reset_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
		dog_sys_reset |-> dog_reset_enable && !dog_restart)
		else $error("reset without enable or despite restart");
	chk_countdown_len: assert property (@(posedge aclk) disable iff (!aresetn)
		(delay_left == 10'h001 && !dog_restart && dog_reset_enable && !ctrl_ok) |=> dog_sys_reset)
		else $error("countdown end missed");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		dog_timeout_flag && !ctrl_ok |=> dog_timeout_flag)
		else $error("timeout flag cleared without software");
	chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("no write response");

	cov_timeout: cover property (@(posedge aclk) disable iff (!aresetn) timeout_pulse);
	cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(dog_irq));
	cov_sys_reset: cover property (@(posedge aclk) disable iff (!aresetn) dog_sys_reset);
	cov_unlocked: cover property (@(posedge aclk) disable iff (!aresetn) ctrl_ok);
endmodule // wdt_top
`default_nettype wire

// File: wdt_top_bench.sv
// testbench: register access, unlock, intervals, timeout, reset countdown of the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_bench
	import wdt_pkg::*;
;
	// ************************************
	// clock, reset and bus signals
	// ************************************
	localparam int unsigned I0 = 1024;
	localparam int unsigned I1 = 2048;
	localparam int unsigned I2 = 4096;
	localparam int unsigned I3 = 8192;
	localparam int unsigned LIMIT = 60000;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic   dog_irq, dog_irq_high_prio, dog_sys_reset;
	wire logic [7:0] vec;
	wire logic [3:0] nat;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          rst_cnt = 0;
	int          d;
	logic [31:0] rd;
	logic [1:0]  rsp;

	wdt_top #(.INT0(I0), .INT1(I1), .INT2(I2), .INT3(I3)) i_wdt_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .dog_irq(dog_irq), .dog_irq_high_prio(dog_irq_high_prio),
		.dog_irq_vector(vec), .dog_irq_natural_prio(nat), .dog_sys_reset(dog_sys_reset)
	);

	initial begin
		forever #2 aclk = ~aclk;
	end

	// ************************************
	// watchdog of the bench itself
	// ************************************
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (dog_sys_reset === 1'b1)
			rst_cnt <= rst_cnt + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			finish_test();
		end
	end

	// ************************************
	// shared tasks
	// ************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// readies are sampled on the falling edge, where they have settled for the next rise
	task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		logic ta, tw, tb;
		ta = 1'b0;
		tw = 1'b0;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic tr;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			if (arvalid & arready) begin
				@(posedge aclk);
				arvalid <= 1'b0;
				@(negedge aclk);
			end
			tr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		axi_write(a, v, rsp);
		check({30'h0, rsp}, 32'h0, "write response okay");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		axi_read(a, rd, rsp);
		check({30'h0, rsp}, 32'h0, "read response okay");
		check(rd, {24'h0, exp}, msg);
	endtask

	task automatic write_ctrl(input logic [7:0] v);
		wr(WDT_ADDR_KEY, WDT_KEY_FIRST);
		wr(WDT_ADDR_KEY, WDT_KEY_SECOND);
		wr(WDT_ADDR_CTRL, v);
	endtask

	// counts cycles until the irq (sel 0) or the system reset request (sel 1) goes high
	task automatic wait_hi(input bit sel, output int n);
		n = 0;
		forever begin
			@(negedge aclk);
			if ((sel ? dog_sys_reset : dog_irq) === 1'b1)
				break;
			n++;
		end
	endtask

	task automatic in_range(input int n, input int exp, input string msg);
		check({31'h0, (n >= exp - 4) && (n <= exp + 4)}, 32'h1, msg);
	endtask

	task automatic end_test(input string name);
		$display("test %s done, %0d mismatches so far", name, error_cnt);
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ************************************
	// test sequence
	// ************************************
	initial begin
		int ints[4];
		ints = '{I0, I1, I2, I3};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(WDT_ADDR_INT_EN, WDT_RST_INT_EN, "int enable reset");
		rd_chk(WDT_ADDR_CTRL, WDT_RST_CTRL, "ctrl reset");
		rd_chk(WDT_ADDR_EXT_EN, WDT_RST_EXT_EN, "ext enable reset");
		rd_chk(WDT_ADDR_EXT_PRI, WDT_RST_EXT_PRI, "ext prio reset");
		rd_chk(WDT_ADDR_CLKCTL, WDT_RST_CLKCTL, "clkctl reset");
		axi_read(8'h10, rd, rsp);
		check({30'h0, rsp}, 32'h2, "unmapped read");
		axi_write(8'h14, 8'hFF, rsp);
		check({30'h0, rsp}, 32'h2, "unmapped write");
		check({24'h0, vec}, 32'h63, "vector");
		check({28'h0, nat}, 32'hB, "natural prio");
		wr(WDT_ADDR_EXT_PRI, 8'h10);
		check({31'h0, dog_irq_high_prio}, 32'h1, "prio high");
		wr(WDT_ADDR_EXT_PRI, 8'h00);
		check({31'h0, dog_irq_high_prio}, 32'h0, "prio low");
		wr(WDT_ADDR_CTRL, 8'h02);
		rd_chk(WDT_ADDR_CTRL, 8'h00, "ctrl locked");
		end_test("registers");
		wr(WDT_ADDR_INT_EN, 8'h80);
		wr(WDT_ADDR_EXT_EN, 8'h10);
		rd_chk(WDT_ADDR_INT_EN, 8'h80, "int enable readback");
		write_ctrl(8'h09);
		rd_chk(WDT_ADDR_CTRL, 8'h08, "flag by write, restart cleared");
		check({31'h0, dog_irq}, 32'h1, "irq from soft flag");
		wr(WDT_ADDR_INT_EN, 8'h00);
		check({31'h0, dog_irq}, 32'h0, "global disable");
		wr(WDT_ADDR_INT_EN, 8'h80);
		wr(WDT_ADDR_EXT_EN, 8'h00);
		check({31'h0, dog_irq}, 32'h0, "dog irq disable");
		wr(WDT_ADDR_EXT_EN, 8'h10);
		check({31'h0, dog_irq}, 32'h1, "irq while flag stays");
		write_ctrl(8'h00);
		check({31'h0, dog_irq}, 32'h0, "flag cleared");
		end_test("interrupt");
		for (int s = 0; s < 4; s++) begin
			wr(WDT_ADDR_CLKCTL, 8'((s << 6) | 3));
			write_ctrl(8'h01);
			wait_hi(1'b0, d);
			in_range(d, ints[s], "interval length");
			rd_chk(WDT_ADDR_CTRL, 8'h08, "flag polled");
		end
		check(rst_cnt, 0, "no reset without enable");
		wr(WDT_ADDR_CLKCTL, 8'h03);
		end_test("intervals");
		write_ctrl(8'h03);
		wait_hi(1'b0, d);
		repeat (100) @(posedge aclk);
		write_ctrl(8'h03);
		repeat (600) @(posedge aclk);
		check(rst_cnt, 0, "restart cancels reset");
		end_test("restart");
		write_ctrl(8'h03);
		wait_hi(1'b0, d);
		wait_hi(1'b1, d);
		in_range(d, WDT_RST_DELAY, "flag to reset");
		rd_chk(WDT_ADDR_CTRL, 8'h0E, "cause flag set");
		@(posedge aclk);
		wait_hi(1'b1, d);
		in_range(d, I0 + WDT_RST_DELAY - 1, "counter restarted at reset");
		end_test("reset path");
		repeat (I0 + 100) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		d = rst_cnt;
		rd_chk(WDT_ADDR_CTRL, 8'h00, "ctrl after reset");
		write_ctrl(8'h02);
		repeat (I0 - 100) @(posedge aclk);
		check(rst_cnt, d, "countdown cleared by reset");
		end_test("system reset");
		finish_test();
	end
endmodule // watchdog_timer_unit_bench
`default_nettype wire
